// ===== core/system_bridge_pkg.sv
// Constants, field layouts and types shared by the system bridge.
package system_bridge_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices (printed offsets) and byte addresses on the register bus.
    localparam logic [19:0] REG_IDX_BRIDGE_CFG  = 20'h40000;
    localparam logic [19:0] REG_IDX_SELECT0_CFG = 20'h40002;
    localparam logic [19:0] REG_IDX_SELECT1_CFG = 20'h40004;
    localparam logic [19:0] REG_IDX_SELECT2_CFG = 20'h40006;
    localparam logic [19:0] REG_IDX_SELECT3_CFG = 20'h40008;
    localparam logic [19:0] REG_IDX_SELECT4_CFG = 20'h4000A;
    localparam logic [31:0] REG_ADDR_BRIDGE_CFG  = {10'h000, REG_IDX_BRIDGE_CFG, 2'b00};
    localparam logic [31:0] REG_ADDR_SELECT0_CFG = {10'h000, REG_IDX_SELECT0_CFG, 2'b00};
    localparam logic [31:0] REG_ADDR_SELECT1_CFG = {10'h000, REG_IDX_SELECT1_CFG, 2'b00};
    localparam logic [31:0] REG_ADDR_SELECT2_CFG = {10'h000, REG_IDX_SELECT2_CFG, 2'b00};
    localparam logic [31:0] REG_ADDR_SELECT3_CFG = {10'h000, REG_IDX_SELECT3_CFG, 2'b00};
    localparam logic [31:0] REG_ADDR_SELECT4_CFG = {10'h000, REG_IDX_SELECT4_CFG, 2'b00};

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and field positions.
    localparam logic [15:0] BRIDGE_CFG_RESET     = 16'h0002;
    localparam logic [8:0]  SELECT0_CFG_RESET    = 9'h005;
    localparam logic [8:0]  SELECTN_CFG_RESET    = 9'h00E;
    localparam int          LANE_POLARITY_BIT    = 15;
    localparam int          SELECT_CFG_WIDTH     = 9;
    localparam int          SELECT_COUNT         = 5;
    localparam int          CFG_WAIT_LSB         = 0;
    localparam int          CFG_WAIT_WIDTH       = 4;
    localparam int          CFG_BYTE_WIDE_BIT    = 4;
    localparam int          CFG_IO_SELECT_BIT    = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Processor address map.
    localparam logic [3:0]  EXT_REGION           = 4'h1;
    localparam int          EXT_SELECT_LSB       = 22;
    localparam logic [7:0]  IPB_REGION           = 8'h20;
    localparam int          IPB_NARROW_BIT       = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // Access sizes and types.
    localparam logic [1:0]  SIZE_BYTE            = 2'h0;
    localparam logic [1:0]  SIZE_HALF            = 2'h1;
    localparam logic [1:0]  SIZE_WORD            = 2'h2;

    typedef struct packed {
        logic [31:0] addr;
        logic        we;
        logic [1:0]  size;
        logic [31:0] wdata;
    } proc_req_t;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_SETUP  = 6'b000010,
        ST_STROBE = 6'b000100,
        ST_IPB    = 6'b001000,
        ST_HOLD   = 6'b010000,
        ST_DONE   = 6'b100000
    } state_t;

endpackage

// ===== core/system_bridge.sv
// System bridge: processor to internal peripheral bus and external expansion bus.
`timescale 1ns/1ps
module system_bridge
(
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          srst,
    // Processor access port.
    input  wire logic                          proc_req,
    input  wire system_bridge_pkg::proc_req_t  proc_cmd,
    output logic                               proc_ack,
    output logic [31:0]                        proc_rdata,
    // Register bus, classic Wishbone slave.
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [31:0]                   wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic [31:0]                        wb_dat_o,
    output logic                               wb_ack_o,
    // Internal peripheral bus.
    output logic                               ipb_stb,
    output logic                               ipb_we,
    output logic                               ipb_wide,
    output logic [15:0]                        ipb_addr,
    output logic [15:0]                        ipb_wdata,
    output logic [1:0]                         ipb_sel,
    input  wire logic [15:0]                   ipb_rdata,
    input  wire logic                          ipb_ack,
    // External expansion bus.
    output logic [21:0]                        ext_addr,
    output logic [15:0]                        ext_data_out,
    input  wire logic [15:0]                   ext_data_in,
    output logic                               ext_data_oe_n,
    output logic                               read_n,
    output logic                               write_n,
    output logic                               flash_select_n,
    output logic                               ram_select_n,
    output logic [1:0]                         byte_lane_selects,
    // Shared select pins and the general-purpose values they replace.
    output logic [2:0]                         shared_select_out,
    output logic [2:0]                         shared_select_oe_n,
    input  wire logic [2:0]                    gpio_d_out,
    input  wire logic [2:0]                    gpio_d_oe_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.
    system_bridge_pkg::state_t    state_reg;
    system_bridge_pkg::state_t    state_next;
    system_bridge_pkg::proc_req_t cmd_reg;
    logic [15:0] bridge_cfg_reg;
    logic [8:0]  select_cfg_reg [system_bridge_pkg::SELECT_COUNT];
    logic [31:0] cur_reg;
    logic [1:0]  beats_left_reg;
    logic [3:0]  wait_cnt_reg;
    logic [3:0]  wait_cfg_reg;
    logic        unit16_reg;
    logic        is_ext_reg;
    logic [2:0]  select_idx_reg;
    logic [4:0]  select_act_n_reg;
    logic [1:0]  lane_act_reg;
    logic [31:0] rdata_reg;
    logic [2:0]  req_select;
    logic        req_ext_hit;
    logic        req_ipb_hit;
    logic [8:0]  req_cfg;
    logic        req_unit16;
    logic [31:0] req_start;
    logic [1:0]  req_beats;
    logic        capture;
    logic [15:0] capture_data;
    logic        enter_beat;
    logic [1:0]  beat_lanes;
    logic [15:0] beat_wdata;
    logic        wb_req;
    logic        wb_wr;
    system_bridge_pkg::proc_req_t nxt_cmd;
    logic [31:0] nxt_cur;
    logic        nxt_unit16;
    logic        nxt_ext;
    logic [2:0]  nxt_select;

    ////////////////////////////////////////////////////////////////////////////////
    // Request decode.
    always_comb
    begin
        req_select  = proc_cmd.addr[system_bridge_pkg::EXT_SELECT_LSB +: 3];
        req_ext_hit = (proc_cmd.addr[31:28] == system_bridge_pkg::EXT_REGION)
                      && (proc_cmd.addr[27:25] == 3'h0)
                      && (req_select < 3'h5);
        req_ipb_hit = (proc_cmd.addr[31:24] == system_bridge_pkg::IPB_REGION);
        req_cfg     = select_cfg_reg[0];
        if (req_ext_hit)
        begin
            req_cfg = select_cfg_reg[req_select];
        end
        if (req_ext_hit)
        begin
            req_unit16 = !req_cfg[system_bridge_pkg::CFG_BYTE_WIDE_BIT];
        end
        else
        begin
            req_unit16 = !proc_cmd.addr[system_bridge_pkg::IPB_NARROW_BIT];
        end
        case (proc_cmd.size)
            system_bridge_pkg::SIZE_WORD: req_start = {proc_cmd.addr[31:2], 2'b00};
            system_bridge_pkg::SIZE_HALF: req_start = {proc_cmd.addr[31:1], 1'b0};
            default:                      req_start = proc_cmd.addr;
        endcase
        case (proc_cmd.size)
            system_bridge_pkg::SIZE_WORD: req_beats = req_unit16 ? 2'd1 : 2'd3;
            system_bridge_pkg::SIZE_HALF: req_beats = req_unit16 ? 2'd0 : 2'd1;
            default:                      req_beats = 2'd0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Access sequencer.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            system_bridge_pkg::ST_IDLE:
            begin
                if (proc_req && req_ext_hit)
                begin
                    state_next = system_bridge_pkg::ST_SETUP;
                end
                else if (proc_req && req_ipb_hit)
                begin
                    state_next = system_bridge_pkg::ST_IPB;
                end
                else if (proc_req)
                begin
                    state_next = system_bridge_pkg::ST_DONE;
                end
            end
            system_bridge_pkg::ST_SETUP:
            begin
                state_next = system_bridge_pkg::ST_STROBE;
            end
            system_bridge_pkg::ST_STROBE:
            begin
                if (wait_cnt_reg == 4'h0)
                begin
                    state_next = system_bridge_pkg::ST_HOLD;
                end
            end
            system_bridge_pkg::ST_IPB:
            begin
                if (ipb_ack)
                begin
                    state_next = system_bridge_pkg::ST_HOLD;
                end
            end
            system_bridge_pkg::ST_HOLD:
            begin
                if (beats_left_reg != 2'd0)
                begin
                    state_next = is_ext_reg ? system_bridge_pkg::ST_SETUP
                                            : system_bridge_pkg::ST_IPB;
                end
                else
                begin
                    state_next = system_bridge_pkg::ST_DONE;
                end
            end
            default:
            begin
                state_next = system_bridge_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg <= system_bridge_pkg::ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cmd_reg        <= '0;
            cur_reg        <= 32'h0000_0000;
            beats_left_reg <= 2'd0;
            unit16_reg     <= 1'b1;
            is_ext_reg     <= 1'b0;
            select_idx_reg <= 3'h0;
            wait_cfg_reg   <= 4'h0;
            wait_cnt_reg   <= 4'h0;
        end
        else if (state_reg == system_bridge_pkg::ST_IDLE && proc_req)
        begin
            cmd_reg        <= proc_cmd;
            cur_reg        <= req_start;
            beats_left_reg <= req_beats;
            unit16_reg     <= req_unit16;
            is_ext_reg     <= req_ext_hit;
            select_idx_reg <= req_select;
            wait_cfg_reg   <= req_cfg[system_bridge_pkg::CFG_WAIT_LSB +:
                                      system_bridge_pkg::CFG_WAIT_WIDTH];
        end
        else if (state_reg == system_bridge_pkg::ST_SETUP)
        begin
            wait_cnt_reg <= wait_cfg_reg;
        end
        else if (state_reg == system_bridge_pkg::ST_STROBE && wait_cnt_reg != 4'h0)
        begin
            wait_cnt_reg <= wait_cnt_reg - 4'h1;
        end
        else if (state_reg == system_bridge_pkg::ST_HOLD && beats_left_reg != 2'd0)
        begin
            cur_reg        <= cur_reg + (unit16_reg ? 32'd2 : 32'd1);
            beats_left_reg <= beats_left_reg - 2'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Beat formatting: values of the beat that starts at the coming edge.
    always_comb
    begin
        nxt_cmd    = cmd_reg;
        nxt_cur    = cur_reg;
        nxt_unit16 = unit16_reg;
        nxt_ext    = is_ext_reg;
        nxt_select = select_idx_reg;
        if (state_reg == system_bridge_pkg::ST_IDLE)
        begin
            nxt_cmd    = proc_cmd;
            nxt_cur    = req_start;
            nxt_unit16 = req_unit16;
            nxt_ext    = req_ext_hit;
            nxt_select = req_select;
        end
        else if (state_reg == system_bridge_pkg::ST_HOLD)
        begin
            nxt_cur = cur_reg + (unit16_reg ? 32'd2 : 32'd1);
        end
        if (!nxt_unit16)
        begin
            beat_lanes = 2'b01;
            beat_wdata = {8'h00, nxt_cmd.wdata[{nxt_cur[1:0], 3'b000} +: 8]};
        end
        else if (nxt_cmd.size == system_bridge_pkg::SIZE_BYTE)
        begin
            beat_lanes = nxt_cur[0] ? 2'b10 : 2'b01;
            beat_wdata = {2{nxt_cmd.wdata[{nxt_cur[1:0], 3'b000} +: 8]}};
        end
        else
        begin
            beat_lanes = 2'b11;
            beat_wdata = nxt_cmd.wdata[{nxt_cur[1], 4'h0} +: 16];
        end
    end

    assign enter_beat = (state_next == system_bridge_pkg::ST_SETUP
                         || state_next == system_bridge_pkg::ST_IPB)
                        && state_reg != system_bridge_pkg::ST_IPB;

    ////////////////////////////////////////////////////////////////////////////////
    // External expansion bus pins.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ext_addr      <= 22'h00_0000;
            ext_data_out  <= 16'h0000;
            ext_data_oe_n <= 1'b1;
            read_n        <= 1'b1;
            write_n       <= 1'b1;
            lane_act_reg  <= 2'b00;
        end
        else
        begin
            if (enter_beat && state_next == system_bridge_pkg::ST_SETUP)
            begin
                ext_addr     <= nxt_cur[21:0];
                ext_data_out <= beat_wdata;
                lane_act_reg <= beat_lanes;
            end
            else if (!is_ext_reg || state_next == system_bridge_pkg::ST_DONE)
            begin
                lane_act_reg <= 2'b00;
            end
            ext_data_oe_n <= !(nxt_cmd.we && nxt_ext
                               && (state_next == system_bridge_pkg::ST_SETUP
                                   || state_next == system_bridge_pkg::ST_STROBE
                                   || state_next == system_bridge_pkg::ST_HOLD));
            read_n  <= !(state_next == system_bridge_pkg::ST_STROBE && !cmd_reg.we);
            write_n <= !(state_next == system_bridge_pkg::ST_STROBE && cmd_reg.we);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            select_act_n_reg <= 5'h1F;
        end
        else
        begin
            select_act_n_reg <= 5'h1F;
            if (nxt_ext && (state_next == system_bridge_pkg::ST_SETUP
                               || state_next == system_bridge_pkg::ST_STROBE
                               || state_next == system_bridge_pkg::ST_HOLD))
            begin
                select_act_n_reg[nxt_select] <= 1'b0;
            end
        end
    end

    // Selects 0 and 1 own their pins; 2 to 4 share with general-purpose lines.
    assign flash_select_n = select_act_n_reg[0];
    assign ram_select_n   = select_act_n_reg[1];
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (select_cfg_reg[i + 2][system_bridge_pkg::CFG_IO_SELECT_BIT])
            begin
                shared_select_out[i]  = select_act_n_reg[i + 2];
                shared_select_oe_n[i] = 1'b0;
            end
            else
            begin
                shared_select_out[i]  = gpio_d_out[i];
                shared_select_oe_n[i] = gpio_d_oe_n[i];
            end
        end
    end

    assign byte_lane_selects = bridge_cfg_reg[system_bridge_pkg::LANE_POLARITY_BIT]
                               ? lane_act_reg : ~lane_act_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Internal peripheral bus; its lines change only for internal accesses.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ipb_stb   <= 1'b0;
            ipb_we    <= 1'b0;
            ipb_wide  <= 1'b1;
            ipb_addr  <= 16'h0000;
            ipb_wdata <= 16'h0000;
            ipb_sel   <= 2'b00;
        end
        else
        begin
            ipb_stb <= (state_next == system_bridge_pkg::ST_IPB);
            if (enter_beat && state_next == system_bridge_pkg::ST_IPB)
            begin
                ipb_we    <= nxt_cmd.we;
                ipb_wide  <= nxt_unit16;
                ipb_addr  <= nxt_cur[15:0];
                ipb_wdata <= beat_wdata;
                ipb_sel   <= beat_lanes;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data assembly.
    assign capture = (state_reg == system_bridge_pkg::ST_STROBE && wait_cnt_reg == 4'h0)
                     || (state_reg == system_bridge_pkg::ST_IPB && ipb_ack);
    assign capture_data = is_ext_reg ? ext_data_in : ipb_rdata;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else if (state_reg == system_bridge_pkg::ST_IDLE && proc_req)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else if (capture && !cmd_reg.we)
        begin
            if (!unit16_reg)
            begin
                rdata_reg[{cur_reg[1:0], 3'b000} +: 8] <= capture_data[7:0];
            end
            else if (cmd_reg.size == system_bridge_pkg::SIZE_BYTE)
            begin
                rdata_reg[{cur_reg[1:0], 3'b000} +: 8] <= cur_reg[0] ? capture_data[15:8]
                                                                     : capture_data[7:0];
            end
            else
            begin
                rdata_reg[{cur_reg[1], 4'h0} +: 16] <= capture_data;
            end
        end
    end

    assign proc_rdata = rdata_reg;
    assign proc_ack   = (state_reg == system_bridge_pkg::ST_DONE);

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers on the register bus.
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            bridge_cfg_reg <= system_bridge_pkg::BRIDGE_CFG_RESET;
        end
        else if (wb_wr && wb_adr_i[31:2] == system_bridge_pkg::REG_ADDR_BRIDGE_CFG[31:2])
        begin
            if (wb_sel_i[0])
            begin
                bridge_cfg_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1])
            begin
                bridge_cfg_reg[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            select_cfg_reg[0] <= system_bridge_pkg::SELECT0_CFG_RESET;
            for (int i = 1; i < system_bridge_pkg::SELECT_COUNT; i++)
            begin
                select_cfg_reg[i] <= system_bridge_pkg::SELECTN_CFG_RESET;
            end
        end
        else if (wb_wr)
        begin
            for (int i = 0; i < system_bridge_pkg::SELECT_COUNT; i++)
            begin
                if (wb_adr_i[31:2] == system_bridge_pkg::REG_ADDR_SELECT0_CFG[31:2]
                                      + 30'(2 * i))
                begin
                    if (wb_sel_i[0])
                    begin
                        select_cfg_reg[i][7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1])
                    begin
                        select_cfg_reg[i][8] <= wb_dat_i[8];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_adr_i[31:2] == system_bridge_pkg::REG_ADDR_BRIDGE_CFG[31:2])
            begin
                wb_dat_o <= {16'h0000, bridge_cfg_reg};
            end
            else if (wb_adr_i[31:2] == system_bridge_pkg::REG_ADDR_SELECT0_CFG[31:2])
            begin
                wb_dat_o <= {23'h000000, select_cfg_reg[0]};
            end
            else if (wb_adr_i[31:2] == system_bridge_pkg::REG_ADDR_SELECT1_CFG[31:2])
            begin
                wb_dat_o <= {23'h000000, select_cfg_reg[1]};
            end
            else if (wb_adr_i[31:2] == system_bridge_pkg::REG_ADDR_SELECT2_CFG[31:2])
            begin
                wb_dat_o <= {23'h000000, select_cfg_reg[2]};
            end
            else if (wb_adr_i[31:2] == system_bridge_pkg::REG_ADDR_SELECT3_CFG[31:2])
            begin
                wb_dat_o <= {23'h000000, select_cfg_reg[3]};
            end
            else if (wb_adr_i[31:2] == system_bridge_pkg::REG_ADDR_SELECT4_CFG[31:2])
            begin
                wb_dat_o <= {23'h000000, select_cfg_reg[4]};
            end
            else
            begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // The processor clock has no path to any pin.

endmodule

// ===== verification/bridge_sva.sv
// Port assertions for the system bridge.
`timescale 1ns/1ps
module bridge_sva
(
    // Watched ports.
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic proc_ack,
    input wire logic ipb_stb,
    input wire logic ext_data_oe_n,
    input wire logic read_n,
    input wire logic write_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_open; $fell(read_n); endsequence
    sequence s_close; ##[1:16] $rose(read_n); endsequence
    a_rd_length: assert property (s_open |-> s_close) else $error("strobe long");
    a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_wb_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    a_rw_apart: assert property (read_n || write_n) else $error("both strobes");
    a_read_float: assert property (!read_n |-> ext_data_oe_n) else $error("drive on read");
    a_write_drive: assert property (!write_n |-> !ext_data_oe_n) else $error("no drive");
    a_ipb_quiet: assert property (!(read_n && write_n) |-> !ipb_stb) else $error("ipb busy");
    a_ack_quiet: assert property (proc_ack |-> read_n && write_n) else $error("late strobe");
endmodule

// ===== verification/ext_mem_model.sv
// Behavioural external flash and RAM.
`timescale 1ns/1ps
module ext_mem_model
(
    // Expansion bus.
    input  wire logic        clk,
    input  wire logic [21:0] ext_addr,
    input  wire logic        read_n,
    input  wire logic        flash_select_n,
    input  wire logic        ram_select_n,
    output logic      [15:0] ext_data_in
);
    logic [15:0] last_q = 16'h0000;
    assign ext_data_in = (!read_n && !(flash_select_n && ram_select_n)) ?
        ext_addr[15:0] ^ 16'h5A5A : ~last_q;
    always_ff @(posedge clk)
        last_q <= ext_data_in;
endmodule

// ===== verification/system_bus_unit_external_bus_tb.sv
// Self-checking bench for the system bridge.
`timescale 1ns/1ps
module system_bus_unit_external_bus_tb;
    logic        clk, srst, proc_req, proc_ack, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        ipb_stb, ipb_we, ipb_wide, ipb_ack, ext_data_oe_n, read_n, write_n;
    logic        flash_select_n, ram_select_n;
    logic [1:0]  ipb_sel, byte_lane_selects, lanes;
    logic [4:0]  cs;
    logic [2:0]  shared_select_out, shared_select_oe_n, gpio_d_out, gpio_d_oe_n;
    logic [3:0]  wb_sel_i;
    logic [15:0] ipb_addr, ipb_wdata, ipb_rdata, ext_data_out, ext_data_in, wdat;
    logic [21:0] ext_addr;
    logic [31:0] proc_rdata, wb_adr_i, wb_dat_i, wb_dat_o, rd;
    system_bridge_pkg::proc_req_t proc_cmd;
    int          mismatches = 0;
    int          n_tests = 0;
    int          rcnt = 0;
    system_bridge uut (.*);
    ext_mem_model mem (.*);
    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        ipb_ack <= ipb_stb && !ipb_ack;
        if (!read_n) rcnt <= rcnt + 1;
        if (!read_n) cs <= {shared_select_out, ram_select_n, flash_select_n};
        if (!write_n) {lanes, wdat} <= {byte_lane_selects, ext_data_out};
    end
    task automatic complete_run(input bit hung);
        mismatches += hung;
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        mismatches += (g !== e);
    endtask
    task automatic wait_ack(input bit p);
        int k;
        for (k = 0; k < 300 && (p ? proc_ack : wb_ack_o) !== 1'h1; k++) @(posedge clk);
        if (k == 300) complete_run(1'h1);
    endtask
    task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
        {wb_we_i, wb_adr_i, wb_dat_i, wb_cyc_i, wb_stb_i} <= {we, a, d, 2'h3};
        wait_ack(1'h0);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge clk);
    endtask
    task automatic pa(input logic [31:0] a, input logic we, input logic [1:0] sz,
                      input logic [31:0] d);
        {proc_cmd, proc_req} <= {a, we, sz, d, 1'h1};
        rcnt = 0;
        wait_ack(1'h1);
        rd = proc_rdata;
        proc_req <= 1'h0;
        @(posedge clk);
    endtask
    task automatic t_regs();
        logic [15:0] rv [6] = '{16'h0002, 16'h0005, 16'h000E, 16'h000E, 16'h000E, 16'h000E};
        for (int i = 0; i < 6; i++)
        begin
            wb(1'h0, 32'h0010_0000 + 8 * i, 32'h0);
            chk(rd, {16'h0, rv[i]});
        end
        wb(1'h0, 32'h0010_0040, 32'h0);
        chk(rd, 32'h0);
        wb(1'h1, 32'h0010_0010, 32'hFFFF_FFFF);
        wb(1'h0, 32'h0010_0010, 32'h0);
        chk(rd, 32'h0000_01FF);
        wb(1'h1, 32'h0010_0010, 32'h0000_0001);
    endtask
    task automatic t_ext();
        pa(32'h1040_0020, 1'h0, 2'h2, 32'h0);
        chk(rd, 32'h5A78_5A7A);
        chk(rcnt, 32'h4);
        chk(cs, 32'h15);
        pa(32'h1000_0006, 1'h0, 2'h1, 32'h0);
        chk(rd[31:16], 32'h5A5C);
        chk(rcnt, 32'h6);
        chk(cs, 32'h16);
        pa(32'h1040_0031, 1'h1, 2'h0, 32'h0000_AB00);
        chk(lanes, 32'h1);
        chk(wdat, 32'hABAB);
        wb(1'h1, 32'h0010_0000, 32'h0000_8000);
        pa(32'h1040_0031, 1'h1, 2'h0, 32'h0000_AB00);
        chk(lanes, 32'h2);
        chk(ipb_addr, 32'h0);
    endtask
    task automatic t_int();
        pa(32'h2000_0004, 1'h0, 2'h1, 32'h0);
        chk(rd[15:0], 32'hBEEF);
        chk(rcnt, 32'h0);
        pa(32'h2001_0004, 1'h0, 2'h1, 32'h0);
        chk(rd[15:0], 32'hEFEF);
        chk(ipb_wide, 32'h0);
        pa(32'h3000_0000, 1'h0, 2'h2, 32'h0);
        chk(rd, 32'h0);
        chk(ext_addr, 32'h31);
    endtask
    task automatic t_pins();
        chk(shared_select_out, 32'h5);
        wb(1'h1, 32'h0010_0018, 32'h0000_010E);
        chk({shared_select_oe_n[0], shared_select_out[0]}, 32'h1);
        pa(32'h1080_0000, 1'h0, 2'h0, 32'h0);
        chk(cs, 32'h13);
        chk(rcnt, 32'hF);
    endtask
    initial
    begin
        {proc_req, proc_cmd, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
        {wb_adr_i, wb_dat_i, wb_sel_i, ipb_rdata} = {64'h0, 4'h3, 16'hBEEF};
        {gpio_d_out, gpio_d_oe_n, srst} = {3'h5, 3'h2, 1'h1};
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        t_regs();
        t_ext();
        t_int();
        t_pins();
        complete_run(1'h0);
    end
endmodule
bind system_bridge bridge_sva chk_u (.*);
